// file: logic/clock_tree_consts.svh
// Offsets, field positions, reset values and fixed divider counts
// Included by the clock tree package users; definitions only
`ifndef CLOCK_TREE_CONSTS_SVH
`define CLOCK_TREE_CONSTS_SVH
`define OFS_SRC_CTRL 8'h00
`define OFS_BUS_CFG 8'h04
`define OFS_KERNEL_SEL 8'h08
`define OFS_SLEEP_EN 8'h0c
`define OFS_STATUS 8'h10
// Source control: enables [5:0], multispeed range [11:8]
`define SRC_EN_LSB 0
`define SRC_EN_W 6
`define MS_RANGE_LSB 8
`define SRC_EN_RESET 6'h02
`define MS_RANGE_4MHZ 4'h6
// Bus config: system select [1:0], ahb [4:2], apb low [7:5], apb high [10:8]
`define SYS_SEL_LSB 0
`define AHB_DIV_LSB 2
`define APB1_DIV_LSB 5
`define APB2_DIV_LSB 8
// Kernel select fields
`define RNG_SEL_LSB 0
`define ADC_SEL_LSB 2
`define ADC_DIV_LSB 4
`define SER_SEL_LSB 6
`define I2C_SEL_LSB 8
`define AUD_SEL_LSB 10
`define LPT_SEL_LSB 12
`define RTC_SEL_LSB 15
`define DAC_SH_BIT 17
// Sleep enables
`define SER_SLP_BIT 0
`define I2C_SLP_BIT 1
`define LPT_SLP_BIT 2
// Fixed divisions, as count minus one
`define TICK_DIV_M1 8'h07
`define RTC_HSE_DIV_M1 8'h1f
`endif

// file: logic/clock_tree_pkg.sv
// Types shared by the clock tree controller
// Source and output clocks are one-cycle ticks in the pclk domain
package clock_tree_pkg;
   typedef struct packed {
      logic fast_internal_rc_osc;
      logic multispeed_internal_rc_osc;
      logic fast_external_osc;
      logic slow_internal_rc_osc;
      logic slow_external_crystal_osc;
      logic pll_system_tap;
      logic vco_first_tap_clock;
      logic vco_second_tap_clock;
      logic external_audio_clock_input;
      logic lowpower_timer_ext_input;
   } src_ticks_t;
   typedef struct packed {
      logic system_clock;
      logic cpu_bus_clock;
      logic cpu_free_running_clock;
      logic shared_bus_clock;
      logic low_speed_periph_bus_clock;
      logic high_speed_periph_bus_clock;
      logic core_tick_ext_clock;
      logic rng_kernel;
      logic adc_kernel;
      logic dac_kernel;
      logic serial_kernel;
      logic two_wire_kernel;
      logic audio_kernel;
      logic lowpower_timer_kernel;
      logic calendar_kernel_clock;
      logic independent_watchdog;
   } clk_ticks_t;
   typedef enum logic [1:0] {
      SYS_MULTISPEED,
      SYS_FAST_INT,
      SYS_FAST_EXT,
      SYS_PLL
   } sys_sel_t;
   typedef enum logic [1:0] {
      SW_RUN,
      SW_DRAIN,
      SW_ARM
   } sw_state_t;
endpackage : clock_tree_pkg

// file: logic/reset_clock_tree_control.sv
// Clock tree controller: source enables, glitch-free muxes, prescalers
// Assumes source clocks arrive as pclk-synchronous ticks; APB slave
`timescale 1ns/1ps
`include "clock_tree_consts.svh"

module tick_divider (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick_in,
   input wire logic [7:0] div_m1,
   output logic tick_out
);
   logic [7:0] count_ff;
   logic tick_out_ff;
   wire wrap = count_ff >= div_m1;
   wire [7:0] nxt_count = tick_in ? (wrap ? 8'h00 : count_ff + 8'h01) : count_ff;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_ff <= 8'h00;
         tick_out_ff <= 1'b0;
      end
      else
      begin
         count_ff <= nxt_count;
         tick_out_ff <= tick_in & wrap;
      end
   end
   assign tick_out = tick_out_ff;
endmodule : tick_divider

module glitchless_sel #(
   parameter int N = 4,
   parameter int W = 2,
   parameter logic [W-1:0] RESET_SEL = '0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [N-1:0] ticks,
   input wire logic [N-1:0] alive,
   input wire logic [W-1:0] sel_req,
   output logic tick_out,
   output logic [W-1:0] cur_sel,
   output logic busy
);
   clock_tree_pkg::sw_state_t state_ff;
   clock_tree_pkg::sw_state_t nxt_state;
   logic [W-1:0] cur_ff;
   logic [W-1:0] tgt_ff;
   logic [W-1:0] nxt_cur;
   logic [W-1:0] nxt_tgt;
   logic tick_out_ff;
   wire req_legal = 32'(sel_req) < N;
   wire old_tick = ticks[cur_ff];
   wire new_tick = ticks[tgt_ff];
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cur = cur_ff;
      nxt_tgt = tgt_ff;
      unique case (state_ff)
         clock_tree_pkg::SW_RUN:
            if (req_legal && sel_req != cur_ff)
            begin
               nxt_tgt = sel_req;
               nxt_state = alive[cur_ff] ? clock_tree_pkg::SW_DRAIN : clock_tree_pkg::SW_ARM;
            end
         clock_tree_pkg::SW_DRAIN:
            if (old_tick || !alive[cur_ff])
               nxt_state = clock_tree_pkg::SW_ARM;
         clock_tree_pkg::SW_ARM:
            if (new_tick)
            begin
               nxt_cur = tgt_ff;
               nxt_state = clock_tree_pkg::SW_RUN;
            end
         default:
            nxt_state = clock_tree_pkg::SW_RUN;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= clock_tree_pkg::SW_RUN;
         cur_ff <= RESET_SEL;
         tgt_ff <= RESET_SEL;
         tick_out_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         cur_ff <= nxt_cur;
         tgt_ff <= nxt_tgt;
         tick_out_ff <= (state_ff == clock_tree_pkg::SW_RUN) && (nxt_state == state_ff) && old_tick;
      end
   end
   assign tick_out = tick_out_ff;
   assign cur_sel = cur_ff;
   assign busy = state_ff != clock_tree_pkg::SW_RUN;
endmodule : glitchless_sel

module reset_clock_tree_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire clock_tree_pkg::src_ticks_t src,
   input wire logic sleep_mode,
   input wire logic stop_mode,
   output logic [5:0] osc_enable,
   output logic [3:0] multispeed_range,
   output clock_tree_pkg::clk_ticks_t clk
);
   logic [5:0] src_en_ff;
   logic [3:0] ms_range_ff;
   logic [10:0] bus_cfg_ff;
   logic [17:0] kern_ff;
   logic [2:0] sleep_en_ff;
   logic pready_ff;
   logic [31:0] prdata_ff;
   logic pslverr_ff;

   // APB decode; one wait state, data from flops
   wire access = psel & penable;
   wire hit_src = paddr == `OFS_SRC_CTRL;
   wire hit_bus = paddr == `OFS_BUS_CFG;
   wire hit_kern = paddr == `OFS_KERNEL_SEL;
   wire hit_slp = paddr == `OFS_SLEEP_EN;
   wire hit_sta = paddr == `OFS_STATUS;
   wire mapped = hit_src | hit_bus | hit_kern | hit_slp | hit_sta;
   wire wr_done = access & pready_ff & pwrite & mapped;

   // System mux status
   logic [1:0] sys_cur;
   logic sys_busy;
   wire [5:0] sys_src_bit = 6'h01 << (
      sys_cur == clock_tree_pkg::SYS_MULTISPEED ? 3'd1 :
      sys_cur == clock_tree_pkg::SYS_FAST_INT ? 3'd0 :
      sys_cur == clock_tree_pkg::SYS_FAST_EXT ? 3'd2 : 3'd5);
   // Independent enables, live source kept on
   wire [5:0] nxt_src_en = pwdata[`SRC_EN_LSB +: `SRC_EN_W] | (sys_busy ? src_en_ff : sys_src_bit);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         src_en_ff <= `SRC_EN_RESET;
         ms_range_ff <= `MS_RANGE_4MHZ;
         bus_cfg_ff <= 11'h000;
         kern_ff <= 18'h00000;
         sleep_en_ff <= 3'h0;
      end
      else if (wr_done)
      begin
         if (hit_src)
         begin
            src_en_ff <= nxt_src_en;
            ms_range_ff <= pwdata[`MS_RANGE_LSB +: 4];
         end
         if (hit_bus)
            bus_cfg_ff <= pwdata[10:0];
         if (hit_kern)
            kern_ff <= pwdata[17:0];
         if (hit_slp)
            sleep_en_ff <= pwdata[2:0];
      end
   end

   // Source ticks gated by their enables
   wire t_fi = src.fast_internal_rc_osc & src_en_ff[0];
   wire t_ms = src.multispeed_internal_rc_osc & src_en_ff[1];
   wire t_fe = src.fast_external_osc & src_en_ff[2];
   wire t_si = src.slow_internal_rc_osc & src_en_ff[3];
   wire t_se = src.slow_external_crystal_osc & src_en_ff[4];
   wire t_pr = src.pll_system_tap & src_en_ff[5];
   wire t_pp = src.vco_first_tap_clock & src_en_ff[5];
   wire t_pq = src.vco_second_tap_clock & src_en_ff[5];

   logic sys_tick;
   glitchless_sel #(.N(4), .W(2), .RESET_SEL(2'(clock_tree_pkg::SYS_MULTISPEED))) u_sys (
      .pclk(pclk),
      .presetn(presetn),
      .ticks({t_pr, t_fe, t_fi, t_ms}),
      .alive({src_en_ff[5], src_en_ff[2], src_en_ff[0], src_en_ff[1]}),
      .sel_req(bus_cfg_ff[`SYS_SEL_LSB +: 2]),
      .tick_out(sys_tick),
      .cur_sel(sys_cur),
      .busy(sys_busy)
   );

   wire [7:0] ahb_m1 = (8'h01 << bus_cfg_ff[`AHB_DIV_LSB +: 3]) - 8'h01;
   wire [7:0] apb1_m1 = (8'h01 << bus_cfg_ff[`APB1_DIV_LSB +: 3]) - 8'h01;
   wire [7:0] apb2_m1 = (8'h01 << bus_cfg_ff[`APB2_DIV_LSB +: 3]) - 8'h01;
   // Converter bus divider 1, 2 or 4
   wire [1:0] adc_div = kern_ff[`ADC_DIV_LSB +: 2];
   wire [7:0] adc_m1 = adc_div == 2'h2 ? 8'h03 : (adc_div == 2'h1 ? 8'h01 : 8'h00);
   logic ahb_tick;
   logic apb1_tick;
   logic apb2_tick;
   logic core_tick_timer_tick;
   logic adc_bus_tick;
   logic rtc_hse_tick;
   tick_divider u_ahb (.pclk(pclk), .presetn(presetn), .tick_in(sys_tick),
      .div_m1(ahb_m1), .tick_out(ahb_tick));
   tick_divider u_apb1 (.pclk(pclk), .presetn(presetn), .tick_in(ahb_tick),
      .div_m1(apb1_m1), .tick_out(apb1_tick));
   tick_divider u_apb2 (.pclk(pclk), .presetn(presetn), .tick_in(ahb_tick),
      .div_m1(apb2_m1), .tick_out(apb2_tick));
   // Core tick from bus clock / 8
   tick_divider u_tick (.pclk(pclk), .presetn(presetn), .tick_in(ahb_tick),
      .div_m1(`TICK_DIV_M1), .tick_out(core_tick_timer_tick));
   // Divider one relies on AHB prescaler one
   tick_divider u_adcd (.pclk(pclk), .presetn(presetn), .tick_in(ahb_tick),
      .div_m1(adc_m1), .tick_out(adc_bus_tick));
   tick_divider u_rtcd (.pclk(pclk), .presetn(presetn), .tick_in(t_fe),
      .div_m1(`RTC_HSE_DIV_M1), .tick_out(rtc_hse_tick));

   // Bus clocks to sleeping peripherals only when allowed
   // Serial bus clock sleep gate
   wire ser_apb = apb2_tick & (~sleep_mode | sleep_en_ff[`SER_SLP_BIT]);
   wire i2c_apb = apb1_tick & (~sleep_mode | sleep_en_ff[`I2C_SLP_BIT]);
   wire lpt_apb = apb1_tick & (~sleep_mode | sleep_en_ff[`LPT_SLP_BIT]);

   logic rng_t, adc_t, ser_t, i2c_t, aud_t, lpt_t, rtc_t;
   logic [1:0] rng_c, adc_c, ser_c, i2c_c, aud_c, rtc_c;
   logic [2:0] lpt_c;
   logic [6:0] k_busy;
   glitchless_sel #(.N(4), .W(2)) u_rng (.pclk(pclk), .presetn(presetn),
      .ticks({t_se, t_si, t_ms, t_pq}),
      .alive({src_en_ff[4], src_en_ff[3], src_en_ff[1], src_en_ff[5]}),
      .sel_req(kern_ff[`RNG_SEL_LSB +: 2]), .tick_out(rng_t), .cur_sel(rng_c),
      .busy(k_busy[0]));
   // Converter kernel mux, bus path last
   glitchless_sel #(.N(4), .W(2)) u_adc (.pclk(pclk), .presetn(presetn),
      .ticks({adc_bus_tick, t_pp, t_fi, sys_tick}),
      .alive({1'b1, src_en_ff[5], src_en_ff[0], 1'b1}),
      .sel_req(kern_ff[`ADC_SEL_LSB +: 2]), .tick_out(adc_t), .cur_sel(adc_c),
      .busy(k_busy[1]));
   glitchless_sel #(.N(4), .W(2)) u_ser (.pclk(pclk), .presetn(presetn),
      .ticks({ser_apb, t_se, t_fi, sys_tick}),
      .alive({1'b1, src_en_ff[4], src_en_ff[0], 1'b1}),
      .sel_req(kern_ff[`SER_SEL_LSB +: 2]), .tick_out(ser_t), .cur_sel(ser_c),
      .busy(k_busy[2]));
   glitchless_sel #(.N(3), .W(2)) u_i2c (.pclk(pclk), .presetn(presetn),
      .ticks({i2c_apb, t_fi, sys_tick}),
      .alive({1'b1, src_en_ff[0], 1'b1}),
      .sel_req(kern_ff[`I2C_SEL_LSB +: 2]), .tick_out(i2c_t), .cur_sel(i2c_c),
      .busy(k_busy[3]));
   glitchless_sel #(.N(3), .W(2)) u_aud (.pclk(pclk), .presetn(presetn),
      .ticks({src.external_audio_clock_input, t_pq, t_fi}),
      .alive({1'b1, src_en_ff[5], src_en_ff[0]}),
      .sel_req(kern_ff[`AUD_SEL_LSB +: 2]), .tick_out(aud_t), .cur_sel(aud_c),
      .busy(k_busy[4]));
   glitchless_sel #(.N(5), .W(3)) u_lpt (.pclk(pclk), .presetn(presetn),
      .ticks({src.lowpower_timer_ext_input, lpt_apb, t_fi, t_se, t_si}),
      .alive({2'b11, src_en_ff[0], src_en_ff[4], src_en_ff[3]}),
      .sel_req(kern_ff[`LPT_SEL_LSB +: 3]), .tick_out(lpt_t), .cur_sel(lpt_c),
      .busy(k_busy[5]));
   // Calendar mux, fast external / 32
   glitchless_sel #(.N(3), .W(2)) u_rtc (.pclk(pclk), .presetn(presetn),
      .ticks({rtc_hse_tick, t_si, t_se}),
      .alive({src_en_ff[2], src_en_ff[3], src_en_ff[4]}),
      .sel_req(kern_ff[`RTC_SEL_LSB +: 2]), .tick_out(rtc_t), .cur_sel(rtc_c),
      .busy(k_busy[6]));

   // Stop-mode capability of each current selection
   wire rng_stop_ok = rng_c >= 2'd2;
   // Serial wakeup on fast internal or crystal
   wire ser_stop_ok = (ser_c == 2'd1) | (ser_c == 2'd2);
   wire i2c_stop_ok = i2c_c == 2'd1;
   wire aud_stop_ok = aud_c == 2'd2;
   // Timer stop on slow sources or pin
   wire lpt_stop_ok = (lpt_c == 3'd0) | (lpt_c == 3'd1) | (lpt_c == 3'd4);
   wire rtc_stop_ok = rtc_c != 2'd2;
   wire run_only = ~stop_mode;

   clock_tree_pkg::clk_ticks_t clk_ff;
   clock_tree_pkg::clk_ticks_t nxt_clk;
   always_comb
   begin
      nxt_clk.system_clock = sys_tick;
      nxt_clk.cpu_bus_clock = ahb_tick & ~sleep_mode;
      nxt_clk.cpu_free_running_clock = ahb_tick;
      nxt_clk.shared_bus_clock = ahb_tick;
      nxt_clk.low_speed_periph_bus_clock = apb1_tick;
      nxt_clk.high_speed_periph_bus_clock = apb2_tick;
      nxt_clk.core_tick_ext_clock = core_tick_timer_tick;
      nxt_clk.rng_kernel = rng_t & (run_only | rng_stop_ok);
      // Converter sources are all Run-only
      nxt_clk.adc_kernel = adc_t & run_only;
      nxt_clk.dac_kernel = t_si & kern_ff[`DAC_SH_BIT];
      nxt_clk.serial_kernel = ser_t & (run_only | ser_stop_ok);
      nxt_clk.two_wire_kernel = i2c_t & (run_only | i2c_stop_ok);
      nxt_clk.audio_kernel = aud_t & (run_only | aud_stop_ok);
      nxt_clk.lowpower_timer_kernel = lpt_t & (run_only | lpt_stop_ok);
      nxt_clk.calendar_kernel_clock = rtc_t & (run_only | rtc_stop_ok);
      nxt_clk.independent_watchdog = src.slow_internal_rc_osc & src_en_ff[3];
   end

   wire [31:0] status_word = {12'h000, k_busy, sys_busy, rtc_stop_ok, lpt_stop_ok,
      aud_stop_ok, i2c_stop_ok, ser_stop_ok, rng_stop_ok, 4'h0, sys_cur};
   wire [31:0] rd_mux =
      hit_src ? {20'h00000, ms_range_ff, 2'h0, src_en_ff} :
      hit_bus ? {21'h000000, bus_cfg_ff} :
      hit_kern ? {14'h0000, kern_ff} :
      hit_slp ? {29'h00000000, sleep_en_ff} :
      hit_sta ? status_word : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
         pslverr_ff <= 1'b0;
         clk_ff <= '0;
      end
      else
      begin
         pready_ff <= access & ~pready_ff;
         prdata_ff <= (access & ~pready_ff & ~pwrite) ? rd_mux : prdata_ff;
         pslverr_ff <= access & ~pready_ff & ~mapped;
         clk_ff <= nxt_clk;
      end
   end

   assign pready = pready_ff;
   assign prdata = prdata_ff;
   assign pslverr = pslverr_ff & pready_ff;
   assign osc_enable = src_en_ff;
   assign multispeed_range = ms_range_ff;
   assign clk = clk_ff;
endmodule : reset_clock_tree_control

// file: sim/reset_clock_tree_control_properties.sv
// Port-level checker for the clock tree controller
// Sees only top ports; attached by the bind at the foot
`timescale 1ns/1ps
module reset_clock_tree_control_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire clock_tree_pkg::src_ticks_t src,
   input wire logic stop_mode,
   input wire logic [5:0] osc_enable,
   input wire clock_tree_pkg::clk_ticks_t clk
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic [5:0] slow_ff;
   logic [7:0] stop_ff;
   logic [3:0] bus_cnt_ff;
   logic [3:0] nxt_bus_cnt;
   logic seen_ff;
   wire live = (src.fast_internal_rc_osc & osc_enable[0]) |
      (src.multispeed_internal_rc_osc & osc_enable[1]) |
      (src.fast_external_osc & osc_enable[2]) | (src.pll_system_tap & osc_enable[5]);
   // Free-running bus ticks, so sleep gating does not starve the count
   wire [3:0] bus_now = bus_cnt_ff + {3'h0, clk.cpu_free_running_clock};
   assign nxt_bus_cnt = clk.core_tick_ext_clock ? 4'h0 : (bus_now == 4'hf ? 4'hf : bus_now);
   // Recent slow ticks, stop history, bus ticks per core tick
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         slow_ff <= '0;
         stop_ff <= '0;
         bus_cnt_ff <= '0;
         seen_ff <= 1'b0;
      end
      else
      begin
         slow_ff <= {slow_ff[4:0], src.slow_internal_rc_osc & osc_enable[3]};
         stop_ff <= {stop_ff[6:0], stop_mode};
         bus_cnt_ff <= nxt_bus_cnt;
         seen_ff <= seen_ff | clk.core_tick_ext_clock;
      end
   end
   a_pready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready not one wait state");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_slverr_map: assert property (pready |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0))
      else $error("pslverr does not match address map");
   a_sys_src_live: assert property (clk.system_clock |-> $past(live, 2))
      else $error("system tick without enabled source tick");
   a_bus_after_sys: assert property (clk.cpu_bus_clock |-> $past(clk.system_clock))
      else $error("bus tick without system tick");
   a_tick_div_eight: assert property (clk.core_tick_ext_clock && seen_ff |->
      bus_now >= 4'h6 && bus_now <= 4'ha)
      else $error("core tick not bus clock over eight");
   a_wdg_slow: assert property (clk.independent_watchdog == slow_ff[0])
      else $error("watchdog tick does not follow slow internal tick");
   a_dac_slow: assert property (clk.dac_kernel |-> slow_ff[0])
      else $error("converter output tick without slow internal tick");
   a_adc_stop: assert property (stop_mode && &stop_ff |-> !clk.adc_kernel)
      else $error("converter kernel ticks in stop");
endmodule : reset_clock_tree_control_checker

bind reset_clock_tree_control reset_clock_tree_control_checker u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .src(src), .stop_mode(stop_mode), .osc_enable(osc_enable), .clk(clk));

// file: sim/test_reset_clock_tree_control.sv
// Self-checking bench for the clock tree controller
// Drives APB and random source ticks; checker bound separately
`timescale 1ns/1ps
`include "clock_tree_consts.svh"
module test_reset_clock_tree_control;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_mode, stop_mode, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, d;
   logic [5:0] osc_enable;
   logic [3:0] multispeed_range;
   logic [1:0] cur_sel;
   clock_tree_pkg::src_ticks_t src;
   clock_tree_pkg::clk_ticks_t clk;
   int num_errors, comparisons;
   int cnt[10];
   reset_clock_tree_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .src(src), .sleep_mode(sleep_mode),
      .stop_mode(stop_mode), .osc_enable(osc_enable), .multispeed_range(multispeed_range),
      .clk(clk));
   always #5 pclk = ~pclk;
   task summarize;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   function logic [31:0] near(input int a, input int b, input int t);
      return {31'h0, (a - b <= t) && (b - a <= t)};
   endfunction : near
   function logic pick(input logic [1:0] s, input clock_tree_pkg::src_ticks_t v);
      return s == 2'd0 ? v.multispeed_internal_rc_osc : s == 2'd1 ? v.fast_internal_rc_osc :
         s == 2'd2 ? v.fast_external_osc : v.pll_system_tap;
   endfunction : pick
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         num_errors++;
         $display("[ERR] %0t no pready", $time);
         summarize();
      end
      @(posedge pclk);
   endtask : apb
   task poll(input logic [31:0] m, input logic [31:0] v);
      int k;
      k = 0;
      do
      begin
         apb(1'b0, `OFS_STATUS, 32'h0);
         k++;
      end while ((rd & m) !== v && k < 100);
      chk(rd & m, v);
      if ((rd & m) !== v)
         summarize();
   endtask : poll
   // Counts: sys, bus, free, core, wdg, serial, adc, slow src, crystal src, sys misses
   task count_win(input int n);
      clock_tree_pkg::src_ticks_t ps;
      clock_tree_pkg::src_ticks_t pp;
      cnt = '{default: 0};
      ps = src;
      pp = src;
      for (int i = 0; i < n; i++)
      begin
         @(posedge pclk);
         cnt[0] += clk.system_clock;
         cnt[1] += clk.cpu_bus_clock;
         cnt[2] += clk.cpu_free_running_clock;
         cnt[3] += clk.core_tick_ext_clock;
         cnt[4] += clk.independent_watchdog;
         cnt[5] += clk.serial_kernel;
         cnt[6] += clk.adc_kernel;
         cnt[7] += src.slow_internal_rc_osc;
         cnt[8] += src.slow_external_crystal_osc;
         // System tick trails its source tick by two edges
         if (i > 1 && clk.system_clock !== pick(cur_sel, pp))
            cnt[9]++;
         pp = ps;
         ps = src;
      end
   endtask : count_win
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, sleep_mode, stop_mode} = '0;
      paddr = '0;
      pwdata = '0;
      src = '0;
      cur_sel = 2'd0;
      num_errors = 0;
      comparisons = 0;
      void'($urandom(32'h4e04cac5));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      fork
         forever
         begin
            @(posedge pclk);
            src <= clock_tree_pkg::src_ticks_t'(10'({$urandom} & {$urandom} & 32'h3ff |
               {22'h0, $urandom % 17 == 0, $urandom % 13 == 0, 6'h0}));
         end
      join_none
      @(posedge pclk);
      chk(32'(osc_enable), 32'h02);
      chk(32'(multispeed_range), 32'h6);
      apb(1'b0, `OFS_SRC_CTRL, 32'h0);
      chk(rd, 32'h602);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk(rd & 32'h1003, 32'h0);
      count_win(200);
      chk(cnt[9], 0);
      apb(1'b1, `OFS_SRC_CTRL, 32'h600);
      chk(32'(osc_enable), 32'h02);
      d = {20'h0, 4'($urandom), 8'h3f};
      apb(1'b1, `OFS_SRC_CTRL, d);
      chk(32'(multispeed_range), 32'(d[11:8]));
      chk(32'(osc_enable), 32'h3f);
      apb(1'b1, 8'h20, 32'hffff_ffff);
      chk(32'(er), 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk({rd[31:1], er}, 32'h1);
      d = $urandom & 32'h7;
      apb(1'b1, `OFS_SLEEP_EN, d);
      apb(1'b0, `OFS_SLEEP_EN, 32'h0);
      chk(rd, d);
      for (int s = 0; s < 4; s++)
      begin
         apb(1'b1, `OFS_BUS_CFG, 32'(s));
         cur_sel = 2'(s);
         poll(32'h1003, 32'(s));
         count_win(150);
         chk(cnt[9], 0);
         chk(32'(cnt[0] > 10), 32'h1);
      end
      apb(1'b1, `OFS_SRC_CTRL, 32'h63e);
      chk(32'(osc_enable), 32'h3e);
      apb(1'b1, `OFS_BUS_CFG, 32'h7);
      count_win(400);
      chk(cnt[9], 0);
      chk(near(cnt[1], cnt[0] / 2, 3), 32'h1);
      chk(near(cnt[3], cnt[1] / 8, 2), 32'h1);
      chk(near(cnt[4], cnt[7], 2), 32'h1);
      for (int c = 2; c >= 0; c -= 2)
      begin
         apb(1'b1, `OFS_KERNEL_SEL, 32'(c) << `SER_SEL_LSB);
         poll(32'h8000, 32'h0);
         stop_mode <= 1'b1;
         repeat (6) @(posedge pclk);
         count_win(300);
         stop_mode <= 1'b0;
         chk(cnt[6], 0);
         chk(c == 2 ? near(cnt[5], cnt[8], 3) : 32'(cnt[5]), c == 2 ? 32'h1 : 32'h0);
      end
      // AHB prescaler one with converter divider one
      apb(1'b1, `OFS_BUS_CFG, 32'h3);
      apb(1'b1, `OFS_KERNEL_SEL, 32'h2000c);
      poll(32'h4000, 32'h0);
      count_win(200);
      chk(near(cnt[6], cnt[2], 3), 32'h1);
      apb(1'b1, `OFS_KERNEL_SEL, 32'h2002c);
      count_win(200);
      chk(near(cnt[6], cnt[2] / 4, 2), 32'h1);
      sleep_mode <= 1'b1;
      repeat (6) @(posedge pclk);
      count_win(200);
      sleep_mode <= 1'b0;
      chk(cnt[1], 0);
      chk(32'(cnt[2] > 0), 32'h1);
      summarize();
   end
endmodule : test_reset_clock_tree_control
